// File: src/can_bit_timing_sync.sv
// Behaviour
// - triple-sample mode votes three samples, half-quantum apart
// - single-sample mode reads once at sample point
// - phase 2 never shorter than two quanta
// - idle falling edge restarts bit at sync
// - no resync after hard sync same bit
// - phase error measured in quanta from sync
// - small phase error acts like hard sync
// - large positive error lengthens phase 1 by jump
// - large negative error shortens phase 2 by jump
// - jump width one to four via two bits
// - only recessive-to-dominant edges synchronize
// - at most one synchronization per bit
// - edge used only if previous sample differs
// - no positive resync while sending dominant
// - timing registers writable only in configuration mode
// - phase 2 from field or max(phase1,2)
// - receiver checks crc, flags mismatch
// - transmitter flags missing acknowledge, retransmits
// - dominant in delimiters, eof, ifs is form error
// - transmitter flags readback mismatch, recessive sent in arbitration or ack slot excepted
// - six identical bits in stuff zone flag error
// - quantum from prescaler 1..64 then divide two
// - sync segment lasts exactly one quantum
// - propagation segment one to eight quanta
// - phase 1 one to eight quanta, ends at sample
//
// The APB interface to the registers and the address map were decided locally.
`timescale 1ns/1ps

module can_bit_timing_sync (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic can_receive_pin,
	input wire can_bt_pkg::frame_ctx_t ctx,
	output logic rx_bit,
	output logic rx_bit_valid,
	output logic bit_start,
	output can_bt_pkg::err_t err,
	output logic error_frame_req,
	output logic retransmit_req
);

	// ==========================================================
	// configuration and status registers
	// ==========================================================
	logic [7:0] cfg1_r, cfg1_nxt; // bit_timing_cfg_1
	logic [7:0] cfg2_r, cfg2_nxt; // bit_timing_cfg_2
	logic [7:0] cfg3_r, cfg3_nxt; // bit_timing_cfg_3
	logic mode_r, mode_nxt; // configuration mode
	logic [4:0] stat_r, stat_nxt; // sticky errors
	logic [31:0] prdata_r, prdata_nxt;
	logic pready_r, pready_nxt;
	logic pslverr_r, pslverr_nxt;
	logic wr_go; // write commits at this edge
	logic [4:0] err_set; // error pulses from the checker
	logic [4:0] clr_mask;
	logic rx_bit_r; // value taken at the last sample point

	assign wr_go = psel & penable & pwrite & pready_r;

	// answer is prepared in setup and shown during the single access cycle
	always_comb begin
		cfg1_nxt = cfg1_r;
		cfg2_nxt = cfg2_r;
		cfg3_nxt = cfg3_r;
		mode_nxt = mode_r;
		clr_mask = 5'h00;
		pready_nxt = psel & ~penable;
		pslverr_nxt = 1'b0;
		prdata_nxt = 32'h00000000;
		if (psel & ~penable) begin
			// decode in setup so the access cycle needs no wait state
			unique case (paddr)
				can_bt_pkg::OFF_CFG_1: prdata_nxt = {24'h000000, cfg1_r};
				can_bt_pkg::OFF_CFG_2: prdata_nxt = {24'h000000, cfg2_r};
				can_bt_pkg::OFF_CFG_3: prdata_nxt = {24'h000000, cfg3_r};
				can_bt_pkg::OFF_MODE: prdata_nxt = {31'h00000000, mode_r};
				can_bt_pkg::OFF_STATUS: prdata_nxt = {26'h0000000, rx_bit_r, stat_r};
				default: pslverr_nxt = 1'b1; // unmapped address
			endcase
		end
		if (wr_go) begin
			// timing words are frozen outside configuration mode
			if (mode_r && paddr == can_bt_pkg::OFF_CFG_1) cfg1_nxt = pwdata[7:0];
			if (mode_r && paddr == can_bt_pkg::OFF_CFG_2) cfg2_nxt = pwdata[7:0];
			if (mode_r && paddr == can_bt_pkg::OFF_CFG_3) cfg3_nxt = pwdata[7:0];
			if (paddr == can_bt_pkg::OFF_MODE) mode_nxt = pwdata[0];
			if (paddr == can_bt_pkg::OFF_STATUS) clr_mask = pwdata[4:0];
		end
		// a new error wins over a clear in the same cycle
		stat_nxt = (stat_r & ~clr_mask) | err_set;
	end

	// register file flops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg1_r <= can_bt_pkg::CFG_1_RST;
			cfg2_r <= can_bt_pkg::CFG_2_RST;
			cfg3_r <= can_bt_pkg::CFG_3_RST;
			mode_r <= can_bt_pkg::MODE_RST;
			stat_r <= 5'h00;
			prdata_r <= 32'h00000000;
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
		end else begin
			cfg1_r <= cfg1_nxt;
			cfg2_r <= cfg2_nxt;
			cfg3_r <= cfg3_nxt;
			mode_r <= mode_nxt;
			stat_r <= stat_nxt;
			prdata_r <= prdata_nxt;
			pready_r <= pready_nxt;
			pslverr_r <= pslverr_nxt;
		end
	end

	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;

	// ==========================================================
	// decoded timing fields
	// ==========================================================
	logic [5:0] baud_prescale_value; // baud_prescale_value
	logic [3:0] sjw_len; // sync_jump_width in quanta, 1..4
	logic [3:0] prop_len; // prop_seg_length in quanta, 1..8
	logic [3:0] ph1_len; // phase1_length in quanta, 1..8
	logic [3:0] ph2_base;
	logic [3:0] ph2_prog;
	logic triple_sample_select; // triple_sample_select
	logic [2:0] ext_r, ext_nxt; // phase 1 lengthening this bit
	logic [2:0] shr_r, shr_nxt; // phase 2 shortening this bit
	logic [3:0] ph1_eff;
	logic [3:0] ph2_eff;

	assign baud_prescale_value = cfg1_r[can_bt_pkg::BRP_LSB +: 6];
	assign sjw_len = {2'b00, cfg1_r[can_bt_pkg::SJW_LSB +: 2]} + 4'h1;
	assign prop_len = {1'b0, cfg2_r[can_bt_pkg::PROP_LSB +: 3]} + 4'h1;
	assign ph1_len = {1'b0, cfg2_r[can_bt_pkg::PH1_LSB +: 3]} + 4'h1;
	assign triple_sample_select = cfg2_r[can_bt_pkg::SAM_BIT];
	// field length or the greater of phase 1 and the processing time
	assign ph2_base = cfg2_r[can_bt_pkg::PH2SRC_BIT] ?
		({1'b0, cfg3_r[can_bt_pkg::PH2_LSB +: 3]} + 4'h1) :
		((ph1_len > can_bt_pkg::IPT_TQ) ? ph1_len : can_bt_pkg::IPT_TQ);
	assign ph2_prog = (ph2_base > can_bt_pkg::IPT_TQ) ? ph2_base : can_bt_pkg::IPT_TQ;
	assign ph1_eff = ph1_len + {1'b0, ext_r};
	// shortening stops at the processing time so the next bit is always computed
	assign ph2_eff = (ph2_prog >= can_bt_pkg::IPT_TQ + {1'b0, shr_r}) ?
		(ph2_prog - {1'b0, shr_r}) : can_bt_pkg::IPT_TQ;

	// ==========================================================
	// receive pin synchroniser and edge detect
	// ==========================================================
	logic rx_meta_r, rx_sync_r, rx_old_r;
	logic fall_edge;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_meta_r <= 1'b1;
			rx_sync_r <= 1'b1;
			rx_old_r <= 1'b1;
		end else begin
			rx_meta_r <= can_receive_pin;
			rx_sync_r <= rx_meta_r;
			rx_old_r <= rx_sync_r;
		end
	end

	// rising edges never steer timing
	assign fall_edge = rx_old_r & ~rx_sync_r;

	// ==========================================================
	// quantum prescaler: 1..64 then a fixed divide by two
	// ==========================================================
	logic [5:0] presc_r, presc_nxt;
	logic half_r, half_nxt; // second half of the quantum
	logic half_tick, tq_tick;
	logic restart; // bit time restart from a synchronization

	assign half_tick = (presc_r == baud_prescale_value);
	assign tq_tick = half_tick & half_r;

	// a restart aligns the quantum grid with the edge
	always_comb begin
		presc_nxt = half_tick ? 6'h00 : presc_r + 6'h01;
		half_nxt = half_tick ? ~half_r : half_r;
		if (restart) begin
			presc_nxt = 6'h00;
			half_nxt = 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			presc_r <= 6'h00;
			half_r <= 1'b0;
		end else begin
			presc_r <= presc_nxt;
			half_r <= half_nxt;
		end
	end

	// ==========================================================
	// bit segment sequencer and synchronization
	// ==========================================================
	can_bt_pkg::seg_t seg_r, seg_nxt;
	logic [3:0] cnt_r, cnt_nxt; // quanta elapsed in the segment
	logic sync_done_r, sync_done_nxt; // a synchronization already happened this bit
	logic [4:0] e_mag; // phase error magnitude in quanta
	logic e_pos, e_neg;
	logic edge_ok, hard_sync, resync_ok, small_err;
	logic sample_pt, wrap;

	// phase error relative to the sync segment
	always_comb begin
		e_mag = 5'h00;
		e_pos = 1'b0;
		e_neg = 1'b0;
		unique case (seg_r)
			can_bt_pkg::SEG_SYNC: e_mag = 5'h00;
			can_bt_pkg::SEG_PROP: begin
				e_mag = {1'b0, cnt_r} + 5'h01;
				e_pos = 1'b1;
			end
			can_bt_pkg::SEG_PH1: begin
				e_mag = {1'b0, prop_len} + {1'b0, cnt_r} + 5'h01;
				e_pos = 1'b1;
			end
			can_bt_pkg::SEG_PH2: begin
				e_mag = {1'b0, ph2_eff} - {1'b0, cnt_r};
				e_neg = 1'b1;
			end
		endcase
	end

	// an edge counts only once per bit and only after a recessive sample
	assign edge_ok = fall_edge & ~sync_done_r & rx_bit_r;
	assign hard_sync = edge_ok & ctx.bus_idle;
	// a dominant sender ignores edges with positive phase error, they are its own echo
	assign resync_ok = edge_ok & ~ctx.bus_idle &
		~(e_pos & ctx.tx_active & ~ctx.tx_bit);
	assign small_err = (e_mag <= {1'b0, sjw_len});
	assign restart = hard_sync | (resync_ok & small_err & (e_pos | e_neg));
	assign sample_pt = tq_tick & ~restart & (seg_r == can_bt_pkg::SEG_PH1) &
		(cnt_r >= ph1_eff - 4'h1);
	assign wrap = tq_tick & ~restart & (seg_r == can_bt_pkg::SEG_PH2) &
		(cnt_r >= ph2_eff - 4'h1);

	// segment stepping, one quantum per tick
	always_comb begin
		seg_nxt = seg_r;
		cnt_nxt = cnt_r;
		ext_nxt = ext_r;
		shr_nxt = shr_r;
		sync_done_nxt = sync_done_r;
		if (restart) begin
			// edge now lies in a fresh sync segment
			seg_nxt = can_bt_pkg::SEG_SYNC;
			cnt_nxt = 4'h0;
			ext_nxt = 3'h0;
			shr_nxt = 3'h0;
			sync_done_nxt = 1'b1;
		end else begin
			if (resync_ok & ~small_err & e_pos) begin
				ext_nxt = sjw_len[2:0];
				sync_done_nxt = 1'b1;
			end
			if (resync_ok & ~small_err & e_neg) begin
				shr_nxt = sjw_len[2:0];
				sync_done_nxt = 1'b1;
			end
			if (resync_ok & ~(e_pos | e_neg)) begin
				sync_done_nxt = 1'b1; // edge inside sync needs no correction
			end
			if (tq_tick) begin
				unique case (seg_r)
					can_bt_pkg::SEG_SYNC: begin
						seg_nxt = can_bt_pkg::SEG_PROP;
						cnt_nxt = 4'h0;
					end
					can_bt_pkg::SEG_PROP: begin
						if (cnt_r >= prop_len - 4'h1) begin
							seg_nxt = can_bt_pkg::SEG_PH1;
							cnt_nxt = 4'h0;
						end else begin
							cnt_nxt = cnt_r + 4'h1;
						end
					end
					can_bt_pkg::SEG_PH1: begin
						if (sample_pt) begin
							seg_nxt = can_bt_pkg::SEG_PH2;
							cnt_nxt = 4'h0;
						end else begin
							cnt_nxt = cnt_r + 4'h1;
						end
					end
					can_bt_pkg::SEG_PH2: begin
						if (wrap) begin
							// new bit: corrections and the sync guard expire
							seg_nxt = can_bt_pkg::SEG_SYNC;
							cnt_nxt = 4'h0;
							ext_nxt = 3'h0;
							shr_nxt = 3'h0;
							sync_done_nxt = 1'b0;
						end else begin
							cnt_nxt = cnt_r + 4'h1;
						end
					end
				endcase
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			seg_r <= can_bt_pkg::SEG_SYNC;
			cnt_r <= 4'h0;
			ext_r <= 3'h0;
			shr_r <= 3'h0;
			sync_done_r <= 1'b0;
		end else begin
			seg_r <= seg_nxt;
			cnt_r <= cnt_nxt;
			ext_r <= ext_nxt;
			shr_r <= shr_nxt;
			sync_done_r <= sync_done_nxt;
		end
	end

	// ==========================================================
	// sampling: single or majority of three
	// ==========================================================
	logic [1:0] hs_r, hs_nxt; // bus at the last two half-quantum ticks
	logic bit_now, rx_valid_r, bit_start_r;

	// hs_r[0] is half a quantum before the sample point, hs_r[1] a full one
	assign bit_now = triple_sample_select ?
		((rx_sync_r & hs_r[0]) | (rx_sync_r & hs_r[1]) | (hs_r[0] & hs_r[1])) :
		rx_sync_r;

	always_comb begin
		hs_nxt = half_tick ? {hs_r[0], rx_sync_r} : hs_r;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hs_r <= 2'b11;
			rx_bit_r <= 1'b1;
			rx_valid_r <= 1'b0;
			bit_start_r <= 1'b0;
		end else begin
			hs_r <= hs_nxt;
			rx_bit_r <= sample_pt ? bit_now : rx_bit_r;
			rx_valid_r <= sample_pt;
			bit_start_r <= wrap | restart;
		end
	end

	assign rx_bit = rx_bit_r;
	assign rx_bit_valid = rx_valid_r;
	assign bit_start = bit_start_r;

	// ==========================================================
	// frame error checks at each sample point
	// ==========================================================
	logic [2:0] run_r, run_nxt; // identical bits seen in the stuff zone
	logic last_r, last_nxt; // previous bit in the stuff zone
	logic [14:0] crc_r, crc_nxt;
	logic crc_bad_r, crc_bad_nxt;
	logic in_stuff_zone, in_crc_span, is_stuff;
	can_bt_pkg::err_t err_r, err_nxt;
	logic efr_r, retx_r;

	assign in_crc_span = (ctx.field == can_bt_pkg::FLD_ARB) |
		(ctx.field == can_bt_pkg::FLD_CTRL_DATA);
	assign in_stuff_zone = in_crc_span | (ctx.field == can_bt_pkg::FLD_CRC);
	assign is_stuff = in_stuff_zone & (run_r == can_bt_pkg::STUFF_RUN);

	// destuffing, crc and the error conditions
	always_comb begin
		run_nxt = run_r;
		last_nxt = last_r;
		crc_nxt = crc_r;
		crc_bad_nxt = crc_bad_r;
		err_nxt = '0;
		if (sample_pt) begin
			if (ctx.field == can_bt_pkg::FLD_IDLE) begin
				run_nxt = 3'h0;
				crc_nxt = 15'h0000;
				crc_bad_nxt = 1'b0;
			end else if (in_stuff_zone) begin
				last_nxt = bit_now;
				if (is_stuff) begin
					err_nxt.stuff = (bit_now == last_r);
					run_nxt = 3'h1;
				end else begin
					run_nxt = (bit_now == last_r) ? run_r + 3'h1 : 3'h1;
					if (in_crc_span) begin
						crc_nxt = {crc_r[13:0], 1'b0} ^
							((bit_now ^ crc_r[14]) ? can_bt_pkg::CRC_POLY : 15'h0000);
					end else begin
						crc_bad_nxt = crc_bad_r | (bit_now != crc_r[14]);
						crc_nxt = {crc_r[13:0], 1'b0};
					end
				end
			end else begin
				run_nxt = 3'h0;
			end
			err_nxt.crc = (ctx.field == can_bt_pkg::FLD_CRC_DELIM) & ~ctx.tx_active &
				crc_bad_r;
			err_nxt.ack = (ctx.field == can_bt_pkg::FLD_ACK_SLOT) & ctx.tx_active &
				bit_now;
			err_nxt.form = ~bit_now & ((ctx.field == can_bt_pkg::FLD_CRC_DELIM) |
				(ctx.field == can_bt_pkg::FLD_ACK_DELIM) | (ctx.field == can_bt_pkg::FLD_EOF) |
				(ctx.field == can_bt_pkg::FLD_IFS));
			// a recessive bit overwritten in arbitration or ack is normal
			err_nxt.bitm = ctx.tx_active & (ctx.field != can_bt_pkg::FLD_IDLE) &
				(bit_now != ctx.tx_bit) & ~(ctx.tx_bit & ((ctx.field == can_bt_pkg::FLD_ARB) |
				(ctx.field == can_bt_pkg::FLD_ACK_SLOT)));
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			run_r <= 3'h0;
			last_r <= 1'b1;
			crc_r <= 15'h0000;
			crc_bad_r <= 1'b0;
			err_r <= '0;
			efr_r <= 1'b0;
			retx_r <= 1'b0;
		end else begin
			run_r <= run_nxt;
			last_r <= last_nxt;
			crc_r <= crc_nxt;
			crc_bad_r <= crc_bad_nxt;
			err_r <= err_nxt;
			efr_r <= |err_nxt;
			retx_r <= ctx.tx_active & (|err_nxt);
		end
	end

	assign err_set = err_nxt;
	assign err = err_r;
	assign error_frame_req = efr_r;
	assign retransmit_req = retx_r;

	// ==========================================================
	// assertions
	// ==========================================================
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence seq_sync_quantum;
		(seg_r == can_bt_pkg::SEG_SYNC) && tq_tick && !restart;
	endsequence

	sequence seq_locked_cfg1_write;
		wr_go && !mode_r && (paddr == can_bt_pkg::OFF_CFG_1);
	endsequence

	AST_SYNC_ONE_TQ: assert property (seq_sync_quantum |=> seg_r == can_bt_pkg::SEG_PROP)
		else $error("sync segment did not end after one quantum");
	AST_SINGLE_SAMPLE: assert property (sample_pt && !triple_sample_select |=> rx_bit_r == $past(rx_sync_r))
		else $error("single sample value wrong");
	AST_TRIPLE_SAMPLE: assert property (sample_pt && triple_sample_select && hs_r[0] && hs_r[1] |=> rx_bit_r)
		else $error("majority vote wrong");
	AST_PH2_MIN: assert property (ph2_eff >= can_bt_pkg::IPT_TQ)
		else $error("phase 2 shorter than processing time");
	AST_CFG_LOCK: assert property (seq_locked_cfg1_write |=> $stable(cfg1_r))
		else $error("timing register changed outside configuration mode");
	AST_ONE_SYNC: assert property (restart |-> !sync_done_r ##1 sync_done_r)
		else $error("second synchronization in one bit");
	AST_FALL_ONLY: assert property (restart |-> $past(rx_sync_r) && !rx_sync_r)
		else $error("restart without falling edge");
	AST_LENGTHEN: assert property (resync_ok && e_pos && !small_err && !restart
		|=> ext_r == sjw_len[2:0])
		else $error("phase 1 not lengthened by jump width");
	AST_STUFF: assert property (sample_pt && is_stuff && bit_now == last_r
		|=> err.stuff ##1 !err.stuff)
		else $error("stuff error missed");
	AST_FORM: assert property (sample_pt && !bit_now && ctx.field == can_bt_pkg::FLD_EOF
		|=> err.form && error_frame_req)
		else $error("form error missed");
	AST_ACK: assert property (sample_pt && bit_now && ctx.tx_active &&
		ctx.field == can_bt_pkg::FLD_ACK_SLOT |=> err.ack && retransmit_req)
		else $error("ack error missed");

endmodule // can_bit_timing_sync

// File: src/can_bt_pkg.sv
package can_bt_pkg;

	// ==========================================================
	// register map (byte addresses, one aligned word each)
	// ==========================================================
	localparam logic [11:0] OFF_CFG_1 = 12'h000; // prescale and jump width
	localparam logic [11:0] OFF_CFG_2 = 12'h004; // segments and sampling
	localparam logic [11:0] OFF_CFG_3 = 12'h008; // phase 2 length
	localparam logic [11:0] OFF_MODE = 12'h00C; // bit 0: configuration mode
	localparam logic [11:0] OFF_STATUS = 12'h010; // sticky errors, write one to clear

	// ==========================================================
	// field positions
	// ==========================================================
	localparam int BRP_LSB = 0; // baud_prescale_value [5:0]
	localparam int SJW_LSB = 6; // sync_jump_width [7:6]
	localparam int PROP_LSB = 0; // prop_seg_length [2:0]
	localparam int PH1_LSB = 3; // phase1_length [5:3]
	localparam int SAM_BIT = 6; // triple_sample_select
	localparam int PH2SRC_BIT = 7; // phase2_source_select
	localparam int PH2_LSB = 0; // phase2_length [2:0]
	localparam int STAT_BITS = 6; // five errors and the last received bit

	// ==========================================================
	// reset values
	// ==========================================================
	localparam logic [7:0] CFG_1_RST = 8'h00;
	localparam logic [7:0] CFG_2_RST = 8'h00;
	localparam logic [7:0] CFG_3_RST = 8'h00;
	localparam logic MODE_RST = 1'b1; // start in configuration mode

	// ==========================================================
	// timing and protocol constants
	// ==========================================================
	localparam logic [3:0] IPT_TQ = 4'h2; // info_processing_time in quanta
	localparam logic [14:0] CRC_POLY = 15'h4599; // crc-15 generator
	localparam logic [2:0] STUFF_RUN = 3'h5; // identical bits before a stuff bit

	// bit time segments, one-hot
	typedef enum logic [3:0] {
		SEG_SYNC = 4'h1,
		SEG_PROP = 4'h2,
		SEG_PH1 = 4'h4,
		SEG_PH2 = 4'h8
	} seg_t;

	// frame field currently on the bus, told by the protocol engine
	typedef enum logic [8:0] {
		FLD_IDLE = 9'h001,
		FLD_ARB = 9'h002, // start of frame and arbitration field
		FLD_CTRL_DATA = 9'h004,
		FLD_CRC = 9'h008,
		FLD_CRC_DELIM = 9'h010,
		FLD_ACK_SLOT = 9'h020,
		FLD_ACK_DELIM = 9'h040,
		FLD_EOF = 9'h080,
		FLD_IFS = 9'h100
	} field_t;

	typedef struct packed {
		field_t field;
		logic tx_active; // this node is transmitting
		logic tx_bit; // level being sent, 1 = recessive
		logic bus_idle;
	} frame_ctx_t;

	typedef struct packed {
		logic crc;
		logic ack;
		logic form;
		logic bitm;
		logic stuff;
	} err_t;

endpackage

// File: tb/can_bus_node.sv
`timescale 1ns/1ps

// ==========================================================
// far-side bus node: drives the receive line bit by bit
// ==========================================================
module can_bus_node (
	input wire logic pclk,
	output logic pin
);
	// the bus rests recessive through its termination, so idle is 1
	initial begin
		pin = 1'b1;
	end

	// send n bits lsb first, each per pclk long, then release to recessive
	task automatic send(input logic [7:0] bits, input int n, input int per);
		for (int i = 0; i < n; i++) begin
			@(posedge pclk);
			pin <= bits[i];
			repeat (per - 1) @(posedge pclk);
		end
		@(posedge pclk);
		pin <= 1'b1;
	endtask
endmodule // can_bus_node

// File: tb/tb_top.sv
`timescale 1ns/1ps

module tb_top;
	// ==========================================================
	// signals
	// ==========================================================
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, q;
	logic pready, pslverr, e, pin, rx_bit, rx_bit_valid, bit_start, efr, rtx;
	can_bt_pkg::frame_ctx_t ctx = '{can_bt_pkg::FLD_IDLE, 1'b0, 1'b1, 1'b1};
	can_bt_pkg::err_t err;
	int fail_count = 0, checked = 0, n, prop, ph1, baud_prescale_value, src, p2f;
	int efr_seen = 0, rtx_seen = 0, vld_seen = 0; // pulse counters for the dut outputs

	always #2 pclk = ~pclk; // 250 MHz

	can_bit_timing_sync dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .can_receive_pin(pin), .ctx(ctx), .rx_bit(rx_bit),
		.rx_bit_valid(rx_bit_valid), .bit_start(bit_start), .err(err),
		.error_frame_req(efr), .retransmit_req(rtx));
	can_bus_node node (.pclk(pclk), .pin(pin));

	// count one-cycle pulses so that none of them goes unwatched
	always @(posedge pclk) begin
		if (efr === 1'b1) efr_seen <= efr_seen + 1;
		if (rtx === 1'b1) rtx_seen <= rtx_seen + 1;
		if (rx_bit_valid === 1'b1) vld_seen <= vld_seen + 1;
	end

	// ==========================================================
	// helpers
	// ==========================================================
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// one apb transfer; waits on pready, never on a fixed count
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge pclk);
		psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1 && k < 50) begin
			k++;
			@(posedge pclk);
		end
		if (k == 50) begin
			// a slave that never answers ends the run
			fail_count++;
			print_verdict();
		end
		q = prdata;
		e = pslverr;
		psel <= 1'b0; penable <= 1'b0;
	endtask

	// bit length in pclk from field values (lengths minus one)
	function automatic int bit_pclk(int b, int pr, int p1, int s, int f);
		int p2;
		p2 = s ? f + 1 : p1 + 1;
		if (p2 < 2) p2 = 2;
		return 2 * (b + 1) * (1 + pr + 1 + p1 + 1 + p2);
	endfunction

	// count pclk between two bit starts, skipping the first partial bit
	task automatic measure(output int c);
		c = 0;
		repeat (2) begin
			while (bit_start !== 1'b1 && c < 2000) begin c++; @(posedge pclk); end
			@(posedge pclk);
			c = 1;
		end
		while (bit_start !== 1'b1 && c < 2000) begin c++; @(posedge pclk); end
	endtask

	task automatic print_verdict();
		$display("compares %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// watchdog far beyond the expected run
	initial begin
		#200000;
		fail_count++;
		print_verdict();
	end

	// ==========================================================
	// main sequence
	// ==========================================================
	initial begin
		void'($urandom(32'h6fc1));
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		// reset values and mode gating
		apb(0, can_bt_pkg::OFF_CFG_1, 0); chk(q, 32'h0);
		apb(0, can_bt_pkg::OFF_MODE, 0); chk(q, 32'h1);
		apb(1, can_bt_pkg::OFF_MODE, 0);
		apb(1, can_bt_pkg::OFF_CFG_2, 32'hFF);
		apb(0, can_bt_pkg::OFF_CFG_2, 0); chk(q, 32'h0);
		apb(0, 12'h014, 0); chk({e, q[7:0]}, 9'h100);
		apb(1, can_bt_pkg::OFF_MODE, 1);
		// random segment lengths kept consistent for software
		for (int i = 0; i < 4; i++) begin
			baud_prescale_value = $urandom_range(0, 3); prop = $urandom_range(0, 7);
			ph1 = $urandom_range(0, 7); src = i % 2;
			p2f = (prop + ph1 + 1 > 7) ? 7 : prop + ph1 + 1;
			apb(1, can_bt_pkg::OFF_CFG_1, baud_prescale_value);
			apb(1, can_bt_pkg::OFF_CFG_3, p2f);
			apb(1, can_bt_pkg::OFF_CFG_2, (src << 7) | ($urandom_range(0, 1) << 6) | (ph1 << 3) | prop);
			apb(0, can_bt_pkg::OFF_CFG_1, 0); chk(q, baud_prescale_value);
			measure(n); chk(n, bit_pclk(baud_prescale_value, prop, ph1, src, p2f));
		end
		// boundary: shortest everything, phase 2 raised to two quanta
		apb(1, can_bt_pkg::OFF_CFG_1, 0);
		apb(1, can_bt_pkg::OFF_CFG_2, 32'h80);
		apb(1, can_bt_pkg::OFF_CFG_3, 0);
		measure(n); chk(n, 10);
		apb(1, can_bt_pkg::OFF_CFG_2, 0);
		// dominant bit in end of frame
		ctx <= '{can_bt_pkg::FLD_EOF, 1'b0, 1'b1, 1'b0};
		// two bit times dominant so a sample lands in it whatever the phase
		node.send(8'h00, 1, 20);
		repeat (30) @(posedge pclk);
		apb(0, can_bt_pkg::OFF_STATUS, 0); chk(q[5:0], 6'h24);
		chk(efr_seen != 0, 1);
		apb(1, can_bt_pkg::OFF_STATUS, 32'h1F);
		apb(0, can_bt_pkg::OFF_STATUS, 0); chk(q[5:0], 6'h20);
		// six dominant bits inside the stuffed zone
		ctx <= '{can_bt_pkg::FLD_ARB, 1'b0, 1'b1, 1'b0};
		// one spare bit so six dominant samples fall inside whatever the phase
		node.send(8'h00, 7, 10);
		ctx <= '{can_bt_pkg::FLD_IDLE, 1'b0, 1'b1, 1'b1};
		repeat (30) @(posedge pclk);
		apb(0, can_bt_pkg::OFF_STATUS, 0); chk(q[5:0], 6'h21);
		chk(rtx_seen, 0);
		chk(vld_seen != 0, 1);
		print_verdict();
	end
endmodule // tb_top
